//--- inc/rivp_pkg.sv
// Constants for the reset and interrupt vector placement block.
// Assumes a program memory addressed in words, 12 address bits wide.
package rivp_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          VNUM_W          = 5;
  localparam int          RESET_SRC_W     = 4;

  // Reset vector when the boot-reset fuse is unprogrammed
  localparam logic [11:0] RESET_ADDR_APP  = 12'h000;
  // Table start with vectors in the application section
  localparam logic [11:0] TABLE_BASE_APP  = 12'h001;
  // Distance from the boot reset address to the relocated table
  localparam logic [11:0] TABLE_OFS_BOOT  = 12'h001;
  // Boot reset address for a 2 Kbyte boot section
  localparam logic [11:0] BOOT_RESET_DEF  = 12'hC00;

  localparam logic [4:0]  VNUM_RESET      = 5'h01;
  localparam logic [4:0]  VNUM_FIRST_IRQ  = 5'h02;
  localparam logic [4:0]  VNUM_LAST_IRQ   = 5'h1A;

  // Fuse level read as programmed
  localparam logic        FUSE_PROGRAMMED = 1'b0;

  // Bit positions of the reset sources
  localparam int          RSRC_PIN        = 0;
  localparam int          RSRC_POWER_ON   = 1;
  localparam int          RSRC_BROWN_OUT  = 2;
  localparam int          RSRC_WATCHDOG   = 3;

endpackage

//--- rtl/rivp_vector_gen.sv
// Reset and interrupt vector address generator for the core fetch logic.
// Assumes the core presents a one-cycle irq_take with the vector number of
// the interrupt it has accepted; priority arbitration happens outside.
module rivp_vector_gen #(
  parameter logic [rivp_pkg::ADDR_W-1:0] BOOT_RESET_ADDR = rivp_pkg::BOOT_RESET_DEF
) (
  input  wire logic                             core_clk,
  input  wire logic                             rst,
  input  wire logic                             boot_reset_fuse,
  input  wire logic                             vector_select_boot,
  input  wire logic [rivp_pkg::RESET_SRC_W-1:0] reset_source,
  input  wire logic                             irq_take,
  input  wire logic [rivp_pkg::VNUM_W-1:0]      irq_vec_num,
  output logic                                  vector_valid,
  output logic      [rivp_pkg::ADDR_W-1:0]      vector_addr,
  output logic      [rivp_pkg::VNUM_W-1:0]      vector_num,
  output logic                                  vector_is_reset
);
  import rivp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address arithmetic

  function automatic logic [ADDR_W-1:0] reset_target(input logic fuse);
    reset_target = (fuse == FUSE_PROGRAMMED) ? BOOT_RESET_ADDR : RESET_ADDR_APP;
  endfunction

  function automatic logic [ADDR_W-1:0] table_base(input logic sel);
    table_base = sel ? ADDR_W'(BOOT_RESET_ADDR + TABLE_OFS_BOOT) : TABLE_BASE_APP;
  endfunction

  // Table base is vector two, so the slot is base plus n minus two
  function automatic logic [ADDR_W-1:0] irq_target(input logic sel,
                                                   input logic [VNUM_W-1:0] num);
    irq_target = ADDR_W'(table_base(sel) + {{(ADDR_W-VNUM_W){1'b0}}, num}
                         - {{(ADDR_W-VNUM_W){1'b0}}, VNUM_FIRST_IRQ});
  endfunction

  function automatic logic legal_irq(input logic [VNUM_W-1:0] num);
    legal_irq = (num >= VNUM_FIRST_IRQ) && (num <= VNUM_LAST_IRQ);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request selection

  logic boot_pending;
  logic reset_req;
  logic irq_ok;
  logic next_valid;

  // Held high through rst so the first edge after release fetches the reset vector
  always_ff @(posedge core_clk) begin
    boot_pending <= rst;
  end

  // Any source, including a level still held, keeps restarting at vector one
  assign reset_req  = boot_pending | (|reset_source);
  // Numbers outside 2..26 have no slot and are dropped without an answer
  assign irq_ok     = irq_take & legal_irq(irq_vec_num);
  assign next_valid = reset_req | irq_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Vector output

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_valid <= 1'b0;
    end else begin
      vector_valid <= next_valid;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_is_reset <= 1'b0;
    end else if (next_valid) begin
      vector_is_reset <= reset_req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_num <= VNUM_RESET;
    end else if (reset_req) begin
      vector_num <= VNUM_RESET;
    end else if (irq_ok) begin
      vector_num <= irq_vec_num;
    end
  end

  // Reset address and table base are chosen independently of each other
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_addr <= RESET_ADDR_APP;
    end else if (reset_req) begin
      vector_addr <= reset_target(boot_reset_fuse);
    end else if (irq_ok) begin
      vector_addr <= irq_target(vector_select_boot, irq_vec_num);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic irq_only;
  assign irq_only = irq_ok & ~reset_req;

  boot_release_a: assert property (
    $fell(rst) |-> ##1 (vector_valid && vector_is_reset && vector_num == VNUM_RESET))
    else $error("no reset vector after reset release");

  reset_source_a: assert property (
    (|reset_source) |=> (vector_valid && vector_is_reset && vector_num == VNUM_RESET))
    else $error("reset source did not give vector one");

  reset_wins_a: assert property (
    (irq_take && |reset_source) |=> vector_is_reset)
    else $error("interrupt beat a reset request");

  fuse_app_a: assert property (
    (reset_req && boot_reset_fuse) |=> (vector_addr == 12'h000))
    else $error("unprogrammed fuse reset not at zero");

  fuse_boot_a: assert property (
    (reset_req && !boot_reset_fuse) |=> (vector_addr == BOOT_RESET_ADDR))
    else $error("programmed fuse reset not at boot address");

  table_app_a: assert property (
    (irq_only && !vector_select_boot)
      |=> (vector_addr == 12'({7'h00, $past(irq_vec_num)} - 12'h001)))
    else $error("application table slot wrong");

  table_boot_a: assert property (
    (irq_only && vector_select_boot)
      |=> (vector_addr == 12'(BOOT_RESET_ADDR + {7'h00, $past(irq_vec_num)} - 12'h001)))
    else $error("relocated table slot wrong");

  ext_first_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h02) |=> (vector_addr == 12'h001))
    else $error("external request 0 not at 0x001");

  watchdog_slot_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h07) |=> (vector_addr == 12'h006))
    else $error("watchdog slot not at 0x006");

  timer_last_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h11) |=> (vector_addr == 12'h010))
    else $error("last timer slot not at 0x010");

  adc_slot_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h16) |=> (vector_addr == 12'h015))
    else $error("converter slot not at 0x015");

  store_ready_slot_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h1A) |=> (vector_addr == 12'h019))
    else $error("last slot not at 0x019");

  boot_table_a: assert property (
    (irq_only && vector_select_boot && irq_vec_num == 5'h02)
      |=> (vector_addr == 12'(BOOT_RESET_ADDR + 12'h001)))
    else $error("relocated table does not start after boot reset");

  ext_second_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h03) |=> (vector_addr == 12'h002))
    else $error("external request 1 not at 0x002");

  pin_group_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h06) |=> (vector_addr == 12'h005))
    else $error("last pin change slot not at 0x005");

  timer_first_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h08) |=> (vector_addr == 12'h007))
    else $error("first timer slot not at 0x007");

  serial_first_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h12) |=> (vector_addr == 12'h011))
    else $error("first serial slot not at 0x011");

  eeprom_slot_a: assert property (
    (irq_only && !vector_select_boot && irq_vec_num == 5'h17) |=> (vector_addr == 12'h016))
    else $error("eeprom slot not at 0x016");

  boot_table_end_a: assert property (
    (irq_only && vector_select_boot && irq_vec_num == 5'h1A)
      |=> (vector_addr == 12'(BOOT_RESET_ADDR + 12'h019)))
    else $error("relocated last slot wrong");

  answer_hold_a: assert property (
    !next_valid |=> ($stable(vector_addr) && $stable(vector_num) && $stable(vector_is_reset)))
    else $error("answer changed with no request");

  irq_answer_a: assert property (
    irq_only |=> (vector_valid && !vector_is_reset && vector_num == $past(irq_vec_num)))
    else $error("accepted interrupt not answered");

  illegal_drop_a: assert property (
    (irq_take && !legal_irq(irq_vec_num) && !reset_req) |=> !vector_valid)
    else $error("illegal vector number answered");

  idle_quiet_a: assert property (
    (!irq_take && !reset_req) |=> !vector_valid)
    else $error("vector issued with no request");

  boot_fuse_c: cover property (reset_req && !boot_reset_fuse ##1 vector_valid);
  app_irq_c: cover property (irq_only && !vector_select_boot ##1 vector_valid);
  boot_irq_c: cover property (irq_only && vector_select_boot ##1 vector_valid);
  collide_c: cover property (irq_ok && |reset_source);

endmodule

//--- bench/rivp_core_model.sv
// Core fetch side model: turns a bench request into a one-cycle irq_take
// and loads its program counter from each answered vector.
// Assumes the bench holds go for exactly one cycle per request.
module rivp_core_model
  import rivp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              go,
  input  wire logic [VNUM_W-1:0] num,
  input  wire logic              vector_valid,
  input  wire logic [ADDR_W-1:0] vector_addr,
  output logic                   irq_take,
  output logic      [VNUM_W-1:0] irq_vec_num,
  output logic      [ADDR_W-1:0] pc
);
  timeunit 1ns;
  timeprecision 1ns;

  always_ff @(posedge core_clk) begin
    irq_take <= rst ? 1'b0 : go;
    // Number is only meaningful with irq_take; scramble it otherwise
    irq_vec_num <= rst ? 5'h00 : (go ? num : ~irq_vec_num);
  end

  always_ff @(posedge core_clk) begin
    if (vector_valid) begin
      pc <= vector_addr;
    end
  end
endmodule

//--- bench/rivp_vector_gen_tb_top.sv
// Testbench for the vector generator with the core model at its far side.
// Assumes the default 2 Kbyte boot section parameter.
module rivp_vector_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rivp_pkg::*;

  logic        core_clk = 1'b0, rst = 1'b1, fuse = 1'b1, sel = 1'b0, go = 1'b0;
  logic [3:0]  src = 4'h0;
  logic [4:0]  num = 5'h00;
  logic        irq_take, vv, vr;
  logic [4:0]  ivn, vn;
  logic [11:0] va, pc;
  int          n_fail = 0, cmp_count = 0, cyc = 0;

  always #25 core_clk = ~core_clk;

  rivp_vector_gen rivp_vector_gen_i (.core_clk(core_clk), .rst(rst),
    .boot_reset_fuse(fuse), .vector_select_boot(sel), .reset_source(src),
    .irq_take(irq_take), .irq_vec_num(ivn), .vector_valid(vv),
    .vector_addr(va), .vector_num(vn), .vector_is_reset(vr));

  rivp_core_model rivp_core_model_i (.core_clk(core_clk), .rst(rst), .go(go),
    .num(num), .vector_valid(vv), .vector_addr(va), .irq_take(irq_take),
    .irq_vec_num(ivn), .pc(pc));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Run takes about 250 cycles; a hang is cut well above that
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset(logic f);
    @(posedge core_clk) fuse <= f;
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk) #1;
    chk("reset valid", 12'(vv), 12'h001);
    chk("reset flag", 12'(vr), 12'h001);
    chk("reset addr", va, f ? RESET_ADDR_APP : BOOT_RESET_DEF);
  endtask

  // Each source alone, fuse alternating, table select set to show independence
  task automatic t_sources;
    for (int b = 0; b < 4; b++) begin
      @(posedge core_clk) src <= 4'(1) << b;
      sel <= 1'b1;
      fuse <= b[0];
      @(posedge core_clk) src <= 4'h0;
      #1;
      chk("source valid", 12'(vv), 12'h001);
      chk("source addr", va, b[0] ? RESET_ADDR_APP : BOOT_RESET_DEF);
      chk("source num", 12'(vn), 12'(VNUM_RESET));
      repeat (2) @(posedge core_clk);
    end
  endtask

  // Reset source lands on the cycle of irq_take; the interrupt is lost
  task automatic t_collide;
    @(posedge core_clk) go <= 1'b1;
    num <= 5'h05;
    @(posedge core_clk) go <= 1'b0;
    src <= 4'h2;
    @(posedge core_clk) src <= 4'h0;
    #1;
    chk("collide flag", 12'(vr), 12'h001);
    chk("collide num", 12'(vn), 12'(VNUM_RESET));
    chk("collide addr", va, fuse ? RESET_ADDR_APP : BOOT_RESET_DEF);
    @(posedge core_clk) #1;
    chk("collide single", 12'(vv), 12'h000);
  endtask

  task automatic t_irq(logic [4:0] n, logic ok);
    @(posedge core_clk) go <= 1'b1;
    num <= n;
    @(posedge core_clk) go <= 1'b0;
    @(posedge core_clk) #1;
    chk("irq valid", 12'(vv), 12'(ok));
    if (ok) begin
      chk("irq flag", 12'(vr), 12'h000);
      chk("irq num", 12'(vn), 12'(n));
      @(posedge core_clk) #1;
      chk("irq pc", pc, (sel ? BOOT_RESET_DEF + TABLE_OFS_BOOT : TABLE_BASE_APP)
          + 12'(n) - 12'h002);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_sources();
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk) sel <= s[0];
      for (int n = 2; n <= 26; n++) t_irq(5'(n), 1'b1);
    end
    t_collide();
    t_irq(5'h00, 1'b0);
    t_irq(5'h01, 1'b0);
    t_irq(5'h1B, 1'b0);
    test_done;
  end
endmodule
